//--- hw/epc_ctrl.sv
// Purpose: Program/erase sequencer for a 512-byte nonvolatile array with Avalon-MM access.
// Assumes: One 20 MHz clock; crystal reference and clock-select strap arrive asynchronously.
// Notes: Byte effects land when the self-timer expires, block and bulk erase by a sweep after it; an aborted cycle changes nothing.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps

// Notes on behaviour
// - 512-byte array at 0x600-0x7FF, on-chip pump
// - Ops timed by 35 us tick from divider
// - Reset copies nonvolatile config and divider
// - Nonvolatile registers use same latch mechanism
// - Armed security blocks 0x6F0-0x6FF changes
// - Secured bytes still read normally
// - Armed security freezes nonvolatile config
// - Armed security forbids block and bulk erase
// - Armed security still allows byte operations
// - Four 128-byte blocks, each protectable
// - Protect bits refresh on reset or read
// - Cleared divider lock freezes divider forever
// - Erased bit is one, shipped as 0xFF
// - Program clears bits only, within one byte
// - Erase sets bits, byte to whole array
// - Programmed byte is old AND data
// - Self-timed mode ends cycle, clears enable
// - Program only unprotected bytes, config or divider copies
// - Mode bits select program or erase kind
// - Enable needs latch and latched valid address
// - Last valid latched write sets target
// - Clearing both bits clears only enable
module epc_ctrl
  import epc_pkg::*;
#(
  parameter logic [15:0] TICKS_PROG_P = TICKS_PROG,
  parameter logic [15:0] TICKS_BYTE_ERASE_P = TICKS_BYTE_ERASE,
  parameter logic [15:0] TICKS_BLOCK_ERASE_P = TICKS_BLOCK_ERASE,
  parameter logic [15:0] TICKS_BULK_ERASE_P = TICKS_BULK_ERASE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Timebase reference
  input wire logic crystal_ref_clock,
  input wire logic timebase_clock_select,
  // Status
  output logic charge_pump_on
);

  // Array bytes, then the nonvolatile config and divider copies.
  logic [7:0] mem [0:NV_WORDS-1] = '{CFG_IDX: CFG_NV_INIT, DIVNVH_IDX: DIV_NV_H_INIT,
                                     DIVNVL_IDX: DIV_NV_L_INIT, default: ERASED_BYTE};

  epc_ctrl_t ctrl_r, wr_ctrl;
  epc_state_t st_r;
  logic [7:0] acr_r, div_hi_r, div_lo_r, tgt_data_r, rd_byte;
  logic [9:0] tgt_r;
  logic [15:0] tick_cnt_r, op_len;
  logic [10:0] pre_cnt_r, div_val;
  logic [8:0] sweep_r, sweep_end_r;
  logic [31:0] rdata_r;
  logic addr_valid_r, tick_r, wait_r, xs1_r, xs2_r, xs3_r, sel1_r, sel2_r;

  function automatic epc_sel_t epc_decode(input logic [ADDR_W-1:0] a);
    if (a >= ARRAY_BASE && a <= ARRAY_LAST) begin
      return SEL_ARRAY;
    end
    case (a)
      CTRL_OFS: return SEL_CTRL;
      ACR_OFS: return SEL_ACR;
      CFG_NV_OFS: return SEL_CFG_NV;
      DIVH_OFS: return SEL_DIVH;
      DIVL_OFS: return SEL_DIVL;
      DIVNVH_OFS: return SEL_DIVNVH;
      DIVNVL_OFS: return SEL_DIVNVL;
      default: return SEL_NONE;
    endcase
  endfunction

  // Decides whether a cycle of the given kind may run on the given storage word.
  function automatic logic op_allowed(input logic [9:0] idx, input epc_mode_t m, input logic sec,
                                      input logic [3:0] bp, input logic unlocked);
    if (idx == CFG_IDX) begin
      return !sec && !m[1];
    end
    if (idx == DIVNVH_IDX || idx == DIVNVL_IDX) begin
      return unlocked && !m[1];
    end
    if (bp[idx[8:7]]) begin
      return 1'b0;
    end
    if (sec && ((idx[8:0] >= SECURE_FIRST && idx[8:0] <= SECURE_LAST) || m[1])) begin
      return 1'b0;
    end
    if (m == MODE_BULK_ERASE && |bp) begin
      return 1'b0;
    end
    return 1'b1;
  endfunction

  epc_sel_t sel;
  epc_mode_t mode;
  logic secure, div_unlocked, req, busy, acc_wr, acc_rd, ctrl_wr;
  logic start_ok, op_done, cycle_end, latch_target;

  assign sel = epc_decode(avs_address);
  assign mode = epc_mode_t'({ctrl_r.erase_mode_hi, ctrl_r.erase_mode_lo});
  assign wr_ctrl = epc_ctrl_t'(avs_writedata[7:0]);
  assign secure = ~mem[CFG_IDX][SEC_BIT];
  assign div_unlocked = div_hi_r[LOCK_BIT];
  assign div_val = {div_hi_r[2:0], div_lo_r};
  assign req = avs_read | avs_write;
  assign busy = (st_r == ST_LOAD) || (st_r == ST_SWEEP);
  assign acc_wr = avs_write && !wait_r;
  assign acc_rd = avs_read && !wait_r;
  assign ctrl_wr = acc_wr && sel == SEL_CTRL;
  assign latch_target = sel == SEL_ARRAY || sel == SEL_CFG_NV || sel == SEL_DIVNVH || sel == SEL_DIVNVL;
  assign start_ok = ctrl_r.bus_latch && addr_valid_r && st_r == ST_IDLE &&
                    op_allowed(tgt_r, mode, secure, acr_r[3:0], div_unlocked);
  assign op_done = st_r == ST_RUN && ctrl_r.program_enable && tick_r && tick_cnt_r == op_len - 16'h0001;
  assign cycle_end = (op_done && !mode[1]) || (st_r == ST_SWEEP && sweep_r == sweep_end_r);
  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign charge_pump_on = ctrl_r.program_enable;

  always_comb begin
    unique case (mode)
      MODE_PROG: op_len = TICKS_PROG_P;
      MODE_BYTE_ERASE: op_len = TICKS_BYTE_ERASE_P;
      MODE_BLOCK_ERASE: op_len = TICKS_BLOCK_ERASE_P;
      MODE_BULK_ERASE: op_len = TICKS_BULK_ERASE_P;
    endcase
  end

  always_comb begin
    case (sel)
      SEL_ARRAY: rd_byte = mem[{1'b0, avs_address[8:0]}];
      SEL_CTRL: rd_byte = ctrl_r;
      SEL_ACR: rd_byte = acr_r;
      SEL_CFG_NV: rd_byte = mem[CFG_IDX];
      SEL_DIVH: rd_byte = div_hi_r;
      SEL_DIVL: rd_byte = div_lo_r;
      SEL_DIVNVH: rd_byte = mem[DIVNVH_IDX];
      SEL_DIVNVL: rd_byte = mem[DIVNVL_IDX];
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus answer: waitrequest drops one cycle after a request is seen, then rises at acceptance.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (req && !busy) begin
      wait_r <= 1'b0;
      rdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // Reference synchronisers; the third stage only serves the edge detector.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
      sel1_r <= 1'b0;
      sel2_r <= 1'b0;
    end else begin
      xs1_r <= crystal_ref_clock;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
      sel1_r <= timebase_clock_select;
      sel2_r <= sel1_r;
    end
  end

  // Prescaler: one tick per divider wrap of bus clocks, or of crystal rising edges when the select strap is high, restarted with each cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_r <= 11'h000;
      tick_r <= 1'b0;
    end else if (st_r != ST_RUN) begin
      pre_cnt_r <= 11'h000;
      tick_r <= 1'b0;
    end else if ((sel2_r ? (xs2_r && !xs3_r) : 1'b1) && div_val != 11'h000) begin
      if (pre_cnt_r >= div_val - 11'h001) begin
        pre_cnt_r <= 11'h000;
        tick_r <= 1'b1;
      end else begin
        pre_cnt_r <= pre_cnt_r + 11'h001;
        tick_r <= 1'b0;
      end
    end else begin
      tick_r <= 1'b0;
    end
  end

  // Latched target: each valid write while latching, with enable clear, replaces address and data.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgt_r <= 10'h000;
      tgt_data_r <= 8'h00;
      addr_valid_r <= 1'b0;
    end else if (!ctrl_r.bus_latch) begin
      addr_valid_r <= 1'b0;
    end else if (acc_wr && latch_target && !ctrl_r.program_enable) begin
      tgt_data_r <= avs_writedata[7:0];
      addr_valid_r <= 1'b1;
      case (sel)
        SEL_CFG_NV: tgt_r <= CFG_IDX;
        SEL_DIVNVH: tgt_r <= DIVNVH_IDX;
        SEL_DIVNVL: tgt_r <= DIVNVL_IDX;
        default: tgt_r <= {1'b0, avs_address[8:0]};
      endcase
    end
  end

  // Control register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= epc_ctrl_t'(CTRL_RST);
    end else begin
      if (ctrl_wr) begin
        ctrl_r.spare <= wr_ctrl.spare;
        ctrl_r.auto_finish <= wr_ctrl.auto_finish;
        if (!ctrl_r.program_enable) begin
          ctrl_r.erase_mode_hi <= wr_ctrl.erase_mode_hi;
          ctrl_r.erase_mode_lo <= wr_ctrl.erase_mode_lo;
        end
        ctrl_r.bus_latch <= wr_ctrl.bus_latch | ctrl_r.program_enable;
        ctrl_r.program_enable <= wr_ctrl.program_enable && (ctrl_r.program_enable || start_ok);
      end
      if (cycle_end && ctrl_r.auto_finish) begin
        ctrl_r.program_enable <= 1'b0;
      end
    end
  end

  // Sequencer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_LOAD;
      tick_cnt_r <= 16'h0000;
      sweep_r <= 9'h000;
      sweep_end_r <= 9'h000;
    end else begin
      unique case (st_r)
        ST_LOAD: st_r <= ST_IDLE;
        ST_IDLE: begin
          tick_cnt_r <= 16'h0000;
          if (ctrl_wr && wr_ctrl.program_enable && start_ok) begin
            st_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!ctrl_r.program_enable) begin
            st_r <= ST_IDLE;
          end else if (op_done) begin
            st_r <= mode[1] ? ST_SWEEP : ST_HOLD;
            sweep_r <= (mode == MODE_BLOCK_ERASE) ? {tgt_r[8:7], 7'h00} : 9'h000;
            sweep_end_r <= (mode == MODE_BLOCK_ERASE) ? {tgt_r[8:7], 7'h7F} : 9'h1FF;
          end else if (tick_r) begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
          end
        end
        ST_SWEEP: begin
          sweep_r <= sweep_r + 9'h001;
          if (sweep_r == sweep_end_r) begin
            st_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!ctrl_r.program_enable) begin
            st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Storage write port: byte results at timer expiry, block and bulk erase by sweep.
  always_ff @(posedge clk) begin
    if (op_done && !mode[1]) begin
      if (mode == MODE_PROG) begin
        mem[tgt_r] <= mem[tgt_r] & tgt_data_r;
      end else begin
        mem[tgt_r] <= ERASED_BYTE;
      end
    end else if (st_r == ST_SWEEP) begin
      mem[{1'b0, sweep_r}] <= ERASED_BYTE;
    end
  end

  // Active configuration and divider registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acr_r <= ACR_RST;
      div_hi_r <= DIVH_RST;
      div_lo_r <= DIVL_RST;
    end else if (st_r == ST_LOAD) begin
      acr_r <= mem[CFG_IDX];
      div_hi_r <= mem[DIVNVH_IDX];
      div_lo_r <= mem[DIVNVL_IDX];
    end else begin
      if (acc_rd && sel == SEL_CFG_NV) begin
        acr_r <= mem[CFG_IDX];
      end
      if (acc_wr && sel == SEL_DIVH && !ctrl_r.bus_latch && div_unlocked) begin
        div_hi_r <= avs_writedata[7:0];
      end
      if (acc_wr && sel == SEL_DIVL && !ctrl_r.bus_latch && div_unlocked) begin
        div_lo_r <= avs_writedata[7:0];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_start;
    ctrl_wr && wr_ctrl.program_enable && !ctrl_r.program_enable;
  endsequence
  sequence s_both_clear;
    ctrl_wr && !wr_ctrl.program_enable && !wr_ctrl.bus_latch && ctrl_r.program_enable;
  endsequence

  chk_enable_needs_latch: assert property ($rose(ctrl_r.program_enable) |->
      $past(ctrl_r.bus_latch) && $past(addr_valid_r))
    else $error("enable set without latch and valid target");
  chk_both_clear_keeps: assert property (s_both_clear |=> ctrl_r.bus_latch && !ctrl_r.program_enable)
    else $error("latch dropped together with enable");
  chk_auto_finish_clear: assert property (cycle_end && ctrl_r.auto_finish |=> !ctrl_r.program_enable)
    else $error("self-timed cycle left enable set");
  chk_secure_range_block: assert property ($rose(ctrl_r.program_enable) |->
      !(secure && tgt_r[9] == 1'b0 && tgt_r[8:0] >= SECURE_FIRST && tgt_r[8:0] <= SECURE_LAST))
    else $error("cycle started in secured range");
  chk_block_protect_hold: assert property ($rose(ctrl_r.program_enable) && !tgt_r[9] |-> !acr_r[tgt_r[8:7]])
    else $error("cycle started in protected block");
  chk_secure_no_bulk: assert property ($rose(ctrl_r.program_enable) && secure |-> !mode[1])
    else $error("block or bulk erase started while secured");
  chk_program_and: assert property (op_done && mode == MODE_PROG |=>
      mem[$past(tgt_r)] == ($past(mem[tgt_r]) & $past(tgt_data_r)))
    else $error("programmed byte is not old AND data");
  chk_cfg_frozen: assert property (secure |=> $stable(mem[CFG_IDX]))
    else $error("armed config register changed");
  chk_divider_locked: assert property (!div_unlocked && st_r != ST_LOAD |=>
      $stable(div_hi_r) && $stable(div_lo_r))
    else $error("locked divider changed");
  chk_reset_load: assert property (st_r == ST_LOAD |=>
      acr_r == $past(mem[CFG_IDX]) && div_lo_r == $past(mem[DIVNVL_IDX]))
    else $error("reset load did not copy nonvolatile values");
  chk_refused_start: assert property ((s_start and !start_ok) |=> !ctrl_r.program_enable ##1 st_r != ST_RUN)
    else $error("refused start raised enable");
endmodule

//--- inc/epc_pkg.sv
// Purpose: Shared constants and types for the nonvolatile byte array controller.
// Assumes: Avalon-MM word addressing, 8-bit registers in the low byte lane.
// Notes: Nonvolatile copies live in the same storage as the array bytes.
package epc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ARRAY_BASE = 12'h600;
  localparam logic [11:0] ARRAY_LAST = 12'h7FF;
  localparam logic [11:0] CTRL_OFS = 12'h010;
  localparam logic [11:0] ACR_OFS = 12'h011;
  localparam logic [11:0] CFG_NV_OFS = 12'h012;
  localparam logic [11:0] DIVH_OFS = 12'h013;
  localparam logic [11:0] DIVL_OFS = 12'h014;
  localparam logic [11:0] DIVNVH_OFS = 12'h015;
  localparam logic [11:0] DIVNVL_OFS = 12'h016;
  localparam int NV_WORDS = 515;
  localparam logic [9:0] CFG_IDX = 10'h200;
  localparam logic [9:0] DIVNVH_IDX = 10'h201;
  localparam logic [9:0] DIVNVL_IDX = 10'h202;
  localparam logic [8:0] SECURE_FIRST = 9'h0F0;
  localparam logic [8:0] SECURE_LAST = 9'h0FF;
  localparam int SEC_BIT = 4;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] CFG_NV_INIT = 8'hF0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ACR_RST = 8'hF0;
  localparam logic [7:0] DIVH_RST = 8'h80;
  localparam logic [7:0] DIVL_RST = 8'h00;
  // Timebase: the divider that yields 35 us from the 20 MHz bus clock.
  localparam int CLK_HZ = 20_000_000;
  localparam int TIMEBASE_NS = 35_000;
  localparam int TIMEBASE_CYCLES = (CLK_HZ / 1000) * TIMEBASE_NS / 1_000_000;
  localparam logic [7:0] DIV_NV_H_INIT = {1'b1, 4'h0, 3'(TIMEBASE_CYCLES >> 8)};
  localparam logic [7:0] DIV_NV_L_INIT = 8'(TIMEBASE_CYCLES);
  // Self-timed cycle lengths in timebase ticks.
  localparam logic [15:0] TICKS_PROG = 16'h011E;
  localparam logic [15:0] TICKS_BYTE_ERASE = 16'h011E;
  localparam logic [15:0] TICKS_BLOCK_ERASE = 16'h023C;
  localparam logic [15:0] TICKS_BULK_ERASE = 16'h023C;

  typedef enum logic [1:0] {
    MODE_PROG = 2'h0,
    MODE_BYTE_ERASE = 2'h1,
    MODE_BLOCK_ERASE = 2'h2,
    MODE_BULK_ERASE = 2'h3
  } epc_mode_t;

  typedef struct packed {
    logic [2:0] spare;
    logic erase_mode_hi;
    logic erase_mode_lo;
    logic bus_latch;
    logic auto_finish;
    logic program_enable;
  } epc_ctrl_t;

  typedef enum {ST_LOAD, ST_IDLE, ST_RUN, ST_HOLD, ST_SWEEP} epc_state_t;

  typedef enum {SEL_NONE, SEL_ARRAY, SEL_CTRL, SEL_ACR, SEL_CFG_NV, SEL_DIVH, SEL_DIVL,
                SEL_DIVNVH, SEL_DIVNVL} epc_sel_t;
endpackage

//--- tb/eeprom_program_erase_ctrl_test.sv
// Purpose: Self-checking bench comparing the controller against a byte-level storage model.
// Assumes: Short self-timed counts of two ticks; divider shrunk by software where allowed.
// Notes: Security arming and divider lock are permanent, so they run last.
`timescale 1ns/10ps
module eeprom_program_erase_ctrl_test;
  import epc_pkg::*;
  logic clk;
  logic rst_b;
  logic xtal;
  logic sel;
  logic pump;
  logic [ADDR_W-1:0] addr;
  logic rd_s;
  logic wr_s;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wait_s;
  logic [7:0] m [0:514];
  logic [7:0] acr_m;
  logic [7:0] divh_m;
  logic [7:0] q;
  logic [7:0] d;
  int i;
  int error_cnt;
  int checked;

  epc_ctrl #(.TICKS_PROG_P(16'h0002), .TICKS_BYTE_ERASE_P(16'h0002), .TICKS_BLOCK_ERASE_P(16'h0002),
             .TICKS_BULK_ERASE_P(16'h0002)) dut (
    .clk(clk), .rst_b(rst_b), .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_s),
    .crystal_ref_clock(xtal), .timebase_clock_select(sel), .charge_pump_on(pump));
  epc_cpu_model cpu (
    .clk(clk), .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wait_s));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    xtal = 1'b0;
    forever #83 xtal = ~xtal;
  end

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // The tests need a few thousand cycles; this bound leaves a wide margin.
  initial begin
    repeat (40_000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: timeout", $time);
    print_verdict();
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    cpu.xfer(1'b0, a, 8'h00, q);
    cmp8(q, exp);
  endtask
  task automatic chk(input int k);
    rdc(ARRAY_BASE + 12'(k), m[k]);
  endtask
  task automatic reset_dut();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    acr_m = m[512];
    divh_m = m[513];
  endtask
  function automatic int idx_of(input logic [11:0] a);
    if (a >= ARRAY_BASE) return int'(a - ARRAY_BASE);
    if (a == CFG_NV_OFS) return 512;
    return (a == DIVNVH_OFS) ? 513 : 514;
  endfunction
  function automatic bit allowed(input logic [1:0] md, input int k);
    bit sec;
    sec = !m[512][SEC_BIT];
    if (k == 512) return !sec;
    if (k > 512) return divh_m[LOCK_BIT];
    if (acr_m[k / 128]) return 1'b0;
    if (sec && k >= 'hF0 && k <= 'hFF) return 1'b0;
    if (sec && md[1]) return 1'b0;
    if (md == 2'h3 && acr_m[3:0] != 4'h0) return 1'b0;
    return 1'b1;
  endfunction

  // Latch a first target, replace it with the real one, start self-timed, poll, unlatch.
  task automatic op(input logic [1:0] md, input logic [11:0] a1, input logic [11:0] a, input logic [7:0] dv);
    int k;
    int b;
    k = idx_of(a);
    cpu.xfer(1'b1, CTRL_OFS, {3'h0, md, 3'b110}, q);
    cpu.xfer(1'b1, a1, 8'h00, q);
    cpu.xfer(1'b1, a, dv, q);
    cpu.xfer(1'b1, CTRL_OFS, {3'h0, md, 3'b111}, q);
    if (allowed(md, k)) begin
      b = (md == 2'h2) ? k / 128 * 128 : 0;
      case (md)
        2'h0: m[k] = m[k] & dv;
        2'h1: m[k] = 8'hFF;
        default: for (int j = 0; j < ((md == 2'h2) ? 128 : 512); j++) m[b + j] = 8'hFF;
      endcase
    end
    do cpu.xfer(1'b0, CTRL_OFS, 8'h00, q); while (q[0] !== 1'b0);
    cpu.xfer(1'b1, CTRL_OFS, 8'h00, q);
    rdc(CTRL_OFS, 8'h00);
  endtask

  initial begin
    error_cnt = 0;
    checked = 0;
    sel = 1'b0;
    rst_b = 1'b0;
    for (int k = 0; k < 512; k++) m[k] = ERASED_BYTE;
    m[512] = CFG_NV_INIT;
    m[513] = DIV_NV_H_INIT;
    m[514] = DIV_NV_L_INIT;
    i = $urandom(7);
    reset_dut();
    rdc(CTRL_OFS, 8'h00);
    rdc(ACR_OFS, acr_m);
    rdc(DIVH_OFS, m[513]);
    rdc(DIVL_OFS, m[514]);
    rdc(12'h5FF, 8'h00);
    chk(511);
    // A non-auto cycle at the long shipped divider is cut short by clearing both bits.
    cpu.xfer(1'b1, CTRL_OFS, 8'h04, q);
    cpu.xfer(1'b1, 12'h610, 8'h00, q);
    cpu.xfer(1'b1, CTRL_OFS, 8'h05, q);
    repeat (2) @(negedge clk);
    cmp8({7'h0, pump}, 8'h01);
    cpu.xfer(1'b1, CTRL_OFS, 8'h00, q);
    rdc(CTRL_OFS, 8'h04);
    chk('h10);
    cpu.xfer(1'b1, CTRL_OFS, 8'h00, q);
    cpu.xfer(1'b1, CTRL_OFS, 8'h01, q);
    rdc(CTRL_OFS, 8'h00);
    cpu.xfer(1'b1, DIVL_OFS, 8'h02, q);
    cpu.xfer(1'b1, DIVH_OFS, 8'h80, q);
    rdc(DIVL_OFS, 8'h02);
    divh_m = 8'h80;
    for (int n = 0; n < 8; n++) begin
      sel <= n[0];
      i = $urandom % 512;
      d = 8'($urandom) | ~m[i];
      op({1'b0, n[1]}, 12'h7FF, ARRAY_BASE + 12'(i), d);
      chk(i);
    end
    sel <= 1'b0;
    op(2'h1, 12'h6A0, 12'h6A0, 8'h00);
    op(2'h0, 12'h6A0, 12'h6A0, 8'hFE);
    op(2'h0, 12'h6A0, 12'h6A0, 8'hFD);
    chk('hA0);
    op(2'h0, 12'h705, 12'h705, 8'h00);
    op(2'h0, 12'h780, 12'h780, 8'h00);
    op(2'h2, 12'h7A0, 12'h740, 8'h00);
    chk('h105);
    chk('h180);
    op(2'h1, 12'h600, CFG_NV_OFS, 8'h00);
    rdc(ACR_OFS, acr_m);
    rdc(CFG_NV_OFS, m[512]);
    acr_m = m[512];
    rdc(ACR_OFS, acr_m);
    op(2'h0, 12'h620, 12'h620, 8'h00);
    chk('h20);
    op(2'h0, 12'h600, CFG_NV_OFS, 8'hF0);
    rdc(CFG_NV_OFS, m[512]);
    acr_m = m[512];
    op(2'h3, 12'h600, 12'h650, 8'h00);
    for (int k = 0; k < 4; k++) chk(k * 128 + 5);
    chk('hA0);
    chk('h180);
    op(2'h0, 12'h600, CFG_NV_OFS, 8'hE0);
    rdc(CFG_NV_OFS, m[512]);
    acr_m = m[512];
    op(2'h0, 12'h600, 12'h6F5, 8'h00);
    chk('hF5);
    op(2'h1, 12'h600, CFG_NV_OFS, 8'h00);
    rdc(CFG_NV_OFS, 8'hE0);
    op(2'h0, 12'h720, 12'h720, 8'h00);
    op(2'h2, 12'h720, 12'h720, 8'h00);
    chk('h120);
    op(2'h1, 12'h720, 12'h720, 8'h00);
    chk('h120);
    op(2'h0, 12'h600, DIVNVH_OFS, 8'h7F);
    reset_dut();
    rdc(DIVH_OFS, m[513]);
    rdc(ACR_OFS, m[512]);
    cpu.xfer(1'b1, DIVL_OFS, 8'h55, q);
    rdc(DIVL_OFS, m[514]);
    op(2'h0, 12'h600, DIVNVL_OFS, 8'h00);
    rdc(DIVNVL_OFS, m[514]);
    print_verdict();
  end
endmodule

//--- tb/epc_cpu_model.sv
// Purpose: Processor-side bus master model that drives the controller registers and array.
// Assumes: The slave answers by lowering waitrequest; only the bench watchdog ends a wait.
// Notes: Write data is inverted on release so a stale value is never mistaken for a live one.
`timescale 1ns/10ps
module epc_cpu_model
  import epc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Avalon-MM master
  output logic [ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
  end

  // One bus cycle; the request holds until a rising edge samples waitrequest low, and ends at that edge.
  task automatic xfer(input bit wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= {24'h0, ~d};
  endtask
endmodule
